// >>> hdtx_pkg.sv
// Purpose: shared constants and types of the hdlc transmit packet path
// Assumes: 16-bit register port with byte addresses as printed
// Notes: one definition per number; hdtx_tx_path and the bench import the whole package
package hdtx_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'hA0;
  localparam logic [7:0] ADDR_DATA = 8'hA2;
  localparam logic [7:0] ADDR_STAT = 8'hA4;
  localparam logic [7:0] ADDR_LATCH = 8'hA6;
  localparam logic [7:0] ADDR_IEN = 8'hA8;
  // packet_control_register fields
  localparam int CTRL_FLUSH = 0;
  localparam int CTRL_NOFCS = 1;
  localparam int CTRL_INV = 2;
  localparam int CTRL_MSB = 3;
  localparam int CTRL_FILL = 4;
  localparam int CTRL_ERR = 5;
  localparam int CTRL_INHIBIT = 6;
  localparam int CTRL_THR_LSB = 8;
  localparam int THR_W = 5;
  localparam logic [15:0] CTRL_RESET = 16'h0800;
  localparam logic [15:0] CTRL_WMASK = 16'h1F7F;
  // queue_write_register fields
  localparam int DATA_BYTE_LSB = 8;
  localparam int DATA_EOP = 0;
  // packet_status_register fields
  localparam int STAT_AVAIL = 0;
  localparam int STAT_EMPTY = 1;
  localparam int STAT_FULL = 2;
  localparam int STAT_LEVEL_LSB = 8;
  localparam int LEVEL_W = 6;
  // packet_status_latched_register fields
  localparam int LAT_AVAIL = 0;
  localparam int LAT_EMPTY = 1;
  localparam int LAT_PEND = 3;
  localparam int LAT_UNDER = 4;
  localparam int LAT_OVER = 5;
  localparam logic [15:0] LAT_RESET = 16'h0000;
  localparam logic [15:0] IEN_WMASK = 16'h003B;
  localparam logic [15:0] IEN_RESET = 16'h0000;
  // framing
  localparam logic [7:0] FLAG_OCTET = 8'h7E;
  localparam logic [15:0] CRC_INIT = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h8408;
  localparam logic [2:0] STUFF_RUN = 3'h5;
  localparam logic [3:0] BYTE_LAST = 4'h7;
  localparam logic [3:0] FCS_LAST = 4'hF;
  localparam int GROUP_SHIFT = 3;
  localparam logic [3:0] PWRUP_CYCLES = 4'h8;
  typedef enum logic [2:0] {
    HDTX_FILL,
    HDTX_OPEN,
    HDTX_DATA,
    HDTX_FCS,
    HDTX_CLOSE
  } hdtx_state_t;
endpackage

// >>> hdtx_buf2.sv
// Purpose: two-entry valid/ready buffer between queue and serialiser
// Assumes: single clock, synchronous active-low reset
// Notes: flush drops both entries in one cycle
`timescale 1ns/1ps
`default_nettype none
module hdtx_buf2 #(
  parameter int WIDTH = 9
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  logic [1:0] cnt_ff;
  logic [WIDTH-1:0] slot0_ff;
  logic [WIDTH-1:0] slot1_ff;
  logic push;
  logic pop;

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("hdtx_buf2: WIDTH must be at least 1");
    end
  endgenerate

  assign in_ready_o = (cnt_ff != 2'h2);
  assign out_valid_o = (cnt_ff != 2'h0);
  assign out_data_o = slot0_ff;
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || flush_i) begin
      cnt_ff <= 2'h0;
    end else if (push && !pop) begin
      cnt_ff <= cnt_ff + 2'h1;
    end else if (pop && !push) begin
      cnt_ff <= cnt_ff - 2'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      slot0_ff <= '0;
      slot1_ff <= '0;
    end else if (pop && push) begin
      if (cnt_ff == 2'h1) begin
        slot0_ff <= in_data_i;
      end else begin
        slot0_ff <= slot1_ff;
        slot1_ff <= in_data_i;
      end
    end else if (pop) begin
      slot0_ff <= slot1_ff;
    end else if (push) begin
      if (cnt_ff == 2'h0) begin
        slot0_ff <= in_data_i;
      end else begin
        slot1_ff <= in_data_i;
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdtx_tx_path.sv
// Purpose: hdlc transmit packet path with queue, framing and registers
// Assumes: one bit leaves per bit_req_i pulse from the overhead inserter
// Notes: register reads answer one cycle after reg_rd_i
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
// Function
// [RQ1] decode five registers, three slots unused
// [RQ2] space flag when free exceeds threshold times eight
// [RQ3] launch inhibit stops after current packet
// [RQ4] append complemented crc-16 as check bytes
// [RQ5] error inject appends uncomplemented crc
// [RQ6] check disable sends packets without check bytes
// [RQ7] idle fill flags or all ones
// [RQ8] byte order lsb first or msb first
// [RQ9] optional inversion of every output bit
// [RQ10] flush empties queue, halts, powers down, ignores writes
// [RQ11] after flush, discard until ram powered up
// [RQ12] push byte and marker on upper byte write
// [RQ13] data register reads as zero
// [RQ14] marker flags final byte of packet
// [RQ15] space flag follows free space versus level
// [RQ16] flush release sets empty latched flag
// [RQ17] zero inserted after five ones in packet
module hdtx_tx_path
  import hdtx_pkg::*;
#(
  parameter int DEPTH = 256
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [1:0] reg_be_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  input wire logic bit_req_i,
  output logic tx_bit_o,
  output logic fifo_ram_pd_o
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);

  generate
    if (DEPTH < 256 || (DEPTH & (DEPTH - 1)) != 0 || DEPTH > 504)
    begin : g_bad_depth
      $error("hdtx_tx_path: DEPTH must be 256");
    end
  endgenerate

  function automatic logic [15:0] crc_step(input logic [15:0] crc,
                                           input logic din);
    crc_step = {1'b0, crc[15:1]} ^ ((crc[0] ^ din) ? CRC_POLY : 16'h0000);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // register port
  logic [15:0] ctrl_ff;
  logic [15:0] ien_ff;
  logic [15:0] lat_ff;
  logic [15:0] lat_set;
  logic [15:0] wmask;
  logic [15:0] nxt_rdata;
  logic [15:0] stat_word;
  logic flush;
  logic flush_q_ff;
  logic flush_fall;
  logic [THR_W-1:0] thr;

  assign wmask = {{8{reg_be_i[1]}}, {8{reg_be_i[0]}}};
  assign flush = ctrl_ff[CTRL_FLUSH];
  assign thr = ctrl_ff[CTRL_THR_LSB +: THR_W];
  assign fifo_ram_pd_o = flush; // [RQ10]

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ctrl_ff <= CTRL_RESET;
    end else if (reg_wr_i && reg_addr_i == ADDR_CTRL) begin
      ctrl_ff <= (ctrl_ff & ~(wmask & CTRL_WMASK)) |
                 (reg_wdata_i & wmask & CTRL_WMASK);
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      ien_ff <= IEN_RESET;
    end else if (reg_wr_i && reg_addr_i == ADDR_IEN) begin
      ien_ff <= (ien_ff & ~(wmask & IEN_WMASK)) |
                (reg_wdata_i & wmask & IEN_WMASK);
    end
  end

  // set wins over a write-one clear in the same cycle
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      lat_ff <= LAT_RESET;
    end else if (reg_wr_i && reg_addr_i == ADDR_LATCH) begin
      lat_ff <= (lat_ff & ~(reg_wdata_i & wmask)) | lat_set;
    end else begin
      lat_ff <= lat_ff | lat_set;
    end
  end

  always_comb begin
    nxt_rdata = 16'h0000;
    if (reg_addr_i == ADDR_CTRL) begin // [RQ1]
      nxt_rdata = ctrl_ff;
    end else if (reg_addr_i == ADDR_DATA) begin
      nxt_rdata = 16'h0000; // [RQ13]
    end else if (reg_addr_i == ADDR_STAT) begin
      nxt_rdata = stat_word;
    end else if (reg_addr_i == ADDR_LATCH) begin
      nxt_rdata = lat_ff;
    end else if (reg_addr_i == ADDR_IEN) begin
      nxt_rdata = ien_ff;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      reg_rdata_o <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // queue: byte plus end marker per entry
  logic [8:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_ff;
  logic [AW-1:0] rd_ptr_ff;
  logic [AW:0] count_ff;
  logic [AW:0] free_bytes;
  logic [AW:0] thr_bytes;
  logic [3:0] pwrup_ff;
  logic discard;
  logic wr_hit;
  logic push_req;
  logic push;
  logic pop;
  logic full;
  logic empty;
  logic avail;
  logic avail_q_ff;
  logic empty_q_ff;
  logic buf_in_ready;
  logic buf_valid;
  logic buf_take;
  logic [8:0] buf_data;

  assign full = (count_ff == DEPTH_C);
  assign empty = (count_ff == '0);
  assign free_bytes = DEPTH_C - count_ff;
  assign thr_bytes = {(AW+1-THR_W-GROUP_SHIFT)'(0), thr,
                      GROUP_SHIFT'(0)} + (AW+1)'(1);
  assign avail = (free_bytes >= thr_bytes); // [RQ2] [RQ15]
  assign discard = flush || (pwrup_ff != 4'h0); // [RQ11]
  // only the upper byte lane commits an entry
  assign wr_hit = reg_wr_i && reg_addr_i == ADDR_DATA && reg_be_i[1];
  assign push_req = wr_hit && !discard; // [RQ10] [RQ12]
  assign push = push_req && !full;
  assign pop = !empty && buf_in_ready && !flush;
  assign stat_word = {2'b00,
                      free_bytes[GROUP_SHIFT +: LEVEL_W],
                      5'b00000, full, empty, avail};

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pwrup_ff <= 4'h0;
    end else if (flush) begin
      pwrup_ff <= PWRUP_CYCLES;
    end else if (pwrup_ff != 4'h0) begin
      pwrup_ff <= pwrup_ff - 4'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (push) begin // [RQ12] [RQ14]
      mem[wr_ptr_ff] <= {reg_wdata_i[DATA_BYTE_LSB +: 8],
                         reg_wdata_i[DATA_EOP]};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || flush) begin // [RQ10]
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff <= '0;
    end else begin
      if (push) begin
        wr_ptr_ff <= wr_ptr_ff + AW'(1);
      end
      if (pop) begin
        rd_ptr_ff <= rd_ptr_ff + AW'(1);
      end
      if (push && !pop) begin
        count_ff <= count_ff + (AW+1)'(1);
      end else if (pop && !push) begin
        count_ff <= count_ff - (AW+1)'(1);
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      avail_q_ff <= 1'b1; // idle level, so no false latch after reset
      empty_q_ff <= 1'b1;
      flush_q_ff <= 1'b0;
    end else begin
      avail_q_ff <= avail;
      empty_q_ff <= empty;
      flush_q_ff <= flush;
    end
  end

  // the stall of the serialiser reaches the queue through buf_in_ready
  hdtx_buf2 #(
    .WIDTH(9)
  ) u_buf (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .flush_i(flush),
    .in_valid_i(pop),
    .in_ready_o(buf_in_ready),
    .in_data_i(mem[rd_ptr_ff]),
    .out_valid_o(buf_valid),
    .out_ready_i(buf_take),
    .out_data_o(buf_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // bit serialiser
  hdtx_state_t state_ff;
  hdtx_state_t nxt_state;
  logic [3:0] pos_ff;
  logic [2:0] ones_ff;
  logic [7:0] byte_ff;
  logic eop_ff;
  logic [15:0] crc_ff;
  logic [15:0] crc_nxt;
  logic [15:0] fcs_ff;
  logic raw_bit;
  logic stuff;
  logic unit_end;
  logic adv;
  logic underflow;
  logic pkt_end_read;

  assign stuff = (state_ff == HDTX_DATA || state_ff == HDTX_FCS ||
                  (state_ff == HDTX_CLOSE && pos_ff == 4'h0)) &&
                 ones_ff == STUFF_RUN; // [RQ17]
  assign adv = bit_req_i && !stuff;
  assign unit_end = (state_ff == HDTX_FCS) ? (pos_ff == FCS_LAST) :
                    (pos_ff == BYTE_LAST);
  assign crc_nxt = crc_step(crc_ff, raw_bit);
  assign buf_take = adv && unit_end && buf_valid && !flush &&
                    (state_ff == HDTX_OPEN ||
                     (state_ff == HDTX_DATA && !eop_ff));
  assign underflow = adv && unit_end && !buf_valid &&
                     (state_ff == HDTX_OPEN ||
                      (state_ff == HDTX_DATA && !eop_ff));
  assign pkt_end_read = pop && mem[rd_ptr_ff][0]; // [RQ14]

  always_comb begin
    raw_bit = 1'b1;
    case (state_ff)
      HDTX_FILL: begin // [RQ7]
        raw_bit = ctrl_ff[CTRL_FILL] ? 1'b1 : FLAG_OCTET[pos_ff[2:0]];
      end
      HDTX_OPEN, HDTX_CLOSE: begin
        raw_bit = FLAG_OCTET[pos_ff[2:0]];
      end
      HDTX_DATA: begin // [RQ8]
        raw_bit = ctrl_ff[CTRL_MSB] ? byte_ff[3'h7 - pos_ff[2:0]] :
                  byte_ff[pos_ff[2:0]];
      end
      HDTX_FCS: begin
        raw_bit = fcs_ff[0];
      end
      default: begin
        raw_bit = 1'b1;
      end
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    if (adv && unit_end) begin
      case (state_ff)
        HDTX_FILL: begin // [RQ3]
          if (buf_valid && !ctrl_ff[CTRL_INHIBIT]) begin
            nxt_state = HDTX_OPEN;
          end
        end
        HDTX_OPEN: begin
          nxt_state = buf_valid ? HDTX_DATA : HDTX_FILL;
        end
        HDTX_DATA: begin
          if (eop_ff) begin // [RQ6]
            nxt_state = ctrl_ff[CTRL_NOFCS] ? HDTX_CLOSE : HDTX_FCS;
          end else if (!buf_valid) begin
            nxt_state = HDTX_FILL;
          end
        end
        HDTX_FCS: begin
          nxt_state = HDTX_CLOSE;
        end
        HDTX_CLOSE: begin
          nxt_state = HDTX_FILL;
        end
        default: begin
          nxt_state = HDTX_FILL;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || flush) begin // [RQ10]
      state_ff <= HDTX_FILL;
      pos_ff <= 4'h0;
    end else if (adv) begin
      state_ff <= nxt_state;
      pos_ff <= unit_end ? 4'h0 : pos_ff + 4'h1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || flush) begin
      ones_ff <= 3'h0;
    end else if (bit_req_i) begin
      if (stuff || (state_ff != HDTX_DATA && state_ff != HDTX_FCS)) begin
        ones_ff <= 3'h0;
      end else begin
        ones_ff <= raw_bit ? ones_ff + 3'h1 : 3'h0;
      end
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      byte_ff <= 8'h00;
      eop_ff <= 1'b0;
    end else if (buf_take) begin
      byte_ff <= buf_data[8:1];
      eop_ff <= buf_data[0];
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i || state_ff == HDTX_OPEN) begin
      crc_ff <= CRC_INIT;
    end else if (adv && state_ff == HDTX_DATA) begin
      crc_ff <= crc_nxt;
    end
  end

  // complemented crc normally, raw crc to force a check error
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      fcs_ff <= 16'h0000;
    end else if (adv && unit_end && state_ff == HDTX_DATA && eop_ff) begin
      fcs_ff <= ctrl_ff[CTRL_ERR] ? crc_nxt : ~crc_nxt; // [RQ4] [RQ5]
    end else if (adv && state_ff == HDTX_FCS) begin
      fcs_ff <= {1'b0, fcs_ff[15:1]};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      tx_bit_o <= 1'b1;
    end else if (bit_req_i) begin
      tx_bit_o <= (stuff ? 1'b0 : raw_bit) ^ ctrl_ff[CTRL_INV]; // [RQ9]
    end
  end

  assign flush_fall = flush_q_ff && !flush;
  always_comb begin
    lat_set = 16'h0000;
    lat_set[LAT_AVAIL] = (avail && !avail_q_ff) || flush_fall;
    lat_set[LAT_EMPTY] = (empty && !empty_q_ff) || flush_fall; // [RQ16]
    lat_set[LAT_PEND] = pkt_end_read;
    lat_set[LAT_UNDER] = underflow;
    lat_set[LAT_OVER] = push_req && full;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);

  a_rd_zero: assert property ( // [RQ13]
    reg_rd_i && reg_addr_i == ADDR_DATA |=> reg_rdata_o == 16'h0000)
    else $error("data register read not zero");
  a_unused_slot: assert property ( // [RQ1]
    reg_rd_i && reg_addr_i == 8'hAC |=> reg_rdata_o == 16'h0000)
    else $error("unused slot read not zero");
  a_avail_above: assert property ( // [RQ2]
    free_bytes > {thr, 3'b000} |-> stat_word[STAT_AVAIL])
    else $error("space flag low above level");
  a_avail_below: assert property ( // [RQ15]
    free_bytes <= {thr, 3'b000} |-> !stat_word[STAT_AVAIL])
    else $error("space flag high at or below level");
  a_flush_clear: assert property ( // [RQ10]
    flush |=> count_ff == '0 && state_ff == HDTX_FILL && !buf_valid)
    else $error("flush did not empty and halt");
  a_lower_nopush: assert property ( // [RQ12]
    reg_wr_i && !reg_be_i[1] && !pop |=> count_ff == $past(count_ff))
    else $error("lower byte write pushed");
  a_discard_wr: assert property ( // [RQ11]
    discard && wr_hit && !pop |=> count_ff == $past(count_ff))
    else $error("write taken during power-up");
  a_inhibit: assert property ( // [RQ3]
    ctrl_ff[CTRL_INHIBIT] && state_ff == HDTX_FILL |=> state_ff != HDTX_OPEN)
    else $error("packet launched while inhibited");
  a_nofcs_close: assert property ( // [RQ6]
    adv && unit_end && state_ff == HDTX_DATA && eop_ff &&
    ctrl_ff[CTRL_NOFCS] && !flush |=> state_ff == HDTX_CLOSE)
    else $error("check bytes sent while disabled");
  a_fcs_value: assert property ( // [RQ4] [RQ5]
    $rose(state_ff == HDTX_FCS) |->
    fcs_ff == ($past(ctrl_ff[CTRL_ERR]) ? $past(crc_nxt) : ~$past(crc_nxt)))
    else $error("check sequence value wrong");
  a_stuff_zero: assert property ( // [RQ17] [RQ9]
    bit_req_i && stuff |=> tx_bit_o == ctrl_ff[CTRL_INV] && ones_ff == 3'h0)
    else $error("stuffed bit not zero");
  a_ones_fill: assert property ( // [RQ7]
    bit_req_i && state_ff == HDTX_FILL && ctrl_ff[CTRL_FILL] |=>
    tx_bit_o == !$past(ctrl_ff[CTRL_INV]))
    else $error("ones fill wrong");
  a_flush_latch: assert property ( // [RQ16]
    flush_fall |=> lat_ff[LAT_EMPTY] && lat_ff[LAT_AVAIL])
    else $error("flush release did not latch empty");

  c_pkt_end: cover property (pkt_end_read);
  c_fcs_sent: cover property (state_ff == HDTX_FCS ##1 state_ff == HDTX_CLOSE);
  c_stuffed: cover property (bit_req_i && stuff);
  c_overflow: cover property (push_req && full);
endmodule
`default_nettype wire

// >>> hdtx_bit_sink.sv
// Purpose: overhead bit inserter model that pulls the serial stream
// Assumes: a bit shows on tx_bit_i the cycle after its request
// Notes: pulls every cycle, or every other cycle when slow_i is high
`timescale 1ns/1ps
`default_nettype none
module hdtx_bit_sink (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic run_i,
  input wire logic slow_i,
  output logic bit_req_o,
  input wire logic tx_bit_i
);
  logic took_ff;
  logic phase_ff;
  logic got[$];
  ////////////////////////////////////////////////////////////////////
  // requests change only on the edge, capture one cycle after each
  always @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      bit_req_o <= 1'b0;
      took_ff <= 1'b0;
      phase_ff <= 1'b0;
    end else begin
      phase_ff <= ~phase_ff;
      bit_req_o <= run_i && (!slow_i || phase_ff);
      took_ff <= bit_req_o;
      if (took_ff) begin
        got.push_back(tx_bit_i);
      end
    end
  end
endmodule
`default_nettype wire

// >>> hdtx_tx_path_tb_top.sv
// Purpose: self-checking bench for the hdlc transmit packet path
// Assumes: register reads answer the cycle after the read strobe
// Notes: frames are searched for in the captured serial stream
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp, msg) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) begin \
      errors++; \
      $display("BAD t=%0t %s got %0h exp %0h", $time, msg, got, exp); \
    end \
  end
module hdtx_tx_path_tb_top;
  import hdtx_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [1:0] be = 2'b00;
  logic [15:0] wdata = 16'h0000;
  logic [15:0] rdata;
  logic bit_req;
  logic tx_bit;
  logic ram_pd;
  logic run = 1'b0;
  logic slow = 1'b0;
  int errors = 0;
  int n_compared = 0;
  ////////////////////////////////////////////////////////////////////
  hdtx_tx_path DUT (.ref_clk_i(ref_clk), .resetn_i(resetn),
    .reg_addr_i(addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_be_i(be), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
    .bit_req_i(bit_req), .tx_bit_o(tx_bit), .fifo_ram_pd_o(ram_pd));
  hdtx_bit_sink sink (.ref_clk_i(ref_clk), .resetn_i(resetn),
    .run_i(run), .slow_i(slow), .bit_req_o(bit_req), .tx_bit_i(tx_bit));
  initial begin
    forever #12.5 ref_clk = ~ref_clk;
  end
  ////////////////////////////////////////////////////////////////////
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d,
      input logic [1:0] b = 2'b11);
    @(posedge ref_clk);
    #1;
    addr = a;
    wdata = d;
    be = b;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_wr = 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    #1;
    addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    reg_rd = 1'b0;
    @(posedge ref_clk);
    #1;
    d = rdata;
  endtask
  task automatic flush;
    wr_reg(ADDR_CTRL, 16'h0001);
    wr_reg(ADDR_CTRL, 16'h0000);
    repeat (12) @(posedge ref_clk);
    #1;
  endtask
  task automatic send_pkt;
    wr_reg(ADDR_DATA, 16'hFF00);
    wr_reg(ADDR_DATA, 16'h5A01);
  endtask
  // expected line bits of the two-byte packet, stuffing included
  task automatic build(input logic [15:0] c, output logic e[$]);
    logic [15:0] crc;
    logic [7:0] by;
    logic r[$];
    int ones;
    logic bt;
    crc = CRC_INIT;
    e = {};
    for (int k = 0; k < 2; k++) begin
      by = k ? 8'h5A : 8'hFF;
      // check bits follow the line order of the data bits
      for (int i = 0; i < 8; i++) begin
        bt = c[CTRL_MSB] ? by[7-i] : by[i];
        r.push_back(bt);
        crc = (crc[0] ^ bt) ? (crc >> 1) ^ CRC_POLY : crc >> 1;
      end
    end
    if (!c[CTRL_NOFCS]) begin
      if (!c[CTRL_ERR]) crc = ~crc;
      for (int i = 0; i < 16; i++) r.push_back(crc[i]);
    end
    for (int i = 0; i < 8; i++) e.push_back(FLAG_OCTET[i]);
    ones = 0;
    foreach (r[i]) begin
      e.push_back(r[i]);
      ones = r[i] ? ones + 1 : 0;
      if (ones == 5) begin
        e.push_back(1'b0);
        ones = 0;
      end
    end
    for (int i = 0; i < 8; i++) e.push_back(FLAG_OCTET[i]);
    if (c[CTRL_INV]) foreach (e[i]) e[i] = ~e[i];
  endtask
  function automatic logic found(input logic e[$]);
    int m;
    for (int s = 0; s + e.size() <= sink.got.size(); s++) begin
      m = 0;
      while (m < e.size() && sink.got[s+m] === e[m]) m++;
      if (m == e.size()) return 1'b1;
    end
    return 1'b0;
  endfunction
  ////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    logic [15:0] d;
    rd_reg(ADDR_CTRL, d);
    `CHK(d, CTRL_RESET, "ctrl reset");
    rd_reg(ADDR_STAT, d);
    `CHK(d, 16'h2003, "status reset");
    rd_reg(ADDR_LATCH, d);
    `CHK(d, LAT_RESET, "latched reset");
    wr_reg(ADDR_IEN, 16'hFFFF);
    rd_reg(ADDR_IEN, d);
    `CHK(d, IEN_WMASK, "enable mask");
    wr_reg(8'hAA, 16'hFFFF);
    rd_reg(8'hAA, d);
    `CHK(d, 16'h0000, "unused slot");
  endtask
  task automatic t_fill_flush;
    logic [15:0] d;
    wr_reg(ADDR_CTRL, 16'h0000);
    for (int i = 0; i < 300; i++) wr_reg(ADDR_DATA, 16'h3300);
    rd_reg(ADDR_STAT, d);
    `CHK(d, 16'h0004, "full status");
    rd_reg(ADDR_LATCH, d);
    `CHK(d[LAT_OVER], 1'b1, "overflow latched");
    rd_reg(ADDR_DATA, d);
    `CHK(d, 16'h0000, "data reads zero");
    wr_reg(ADDR_CTRL, 16'h0001);
    rd_reg(ADDR_STAT, d);
    `CHK(d, 16'h2003, "flushed");
    `CHK(ram_pd, 1'b1, "ram down");
    wr_reg(ADDR_DATA, 16'h1100);
    rd_reg(ADDR_STAT, d);
    `CHK(d, 16'h2003, "write in flush");
    wr_reg(ADDR_LATCH, 16'hFFFF);
    wr_reg(ADDR_CTRL, 16'h0000);
    wr_reg(ADDR_DATA, 16'h2201); // still powering up, dropped
    rd_reg(ADDR_LATCH, d);
    `CHK(d, 16'h0003, "release latch");
    rd_reg(ADDR_STAT, d);
    `CHK(d, 16'h2003, "power-up drop");
    `CHK(ram_pd, 1'b0, "ram up");
    repeat (10) @(posedge ref_clk);
    // entries drain into the buffer at once; the end marker shows a push
    wr_reg(ADDR_DATA, 16'h2201, 2'b01);
    rd_reg(ADDR_LATCH, d);
    `CHK(d, 16'h0003, "low lane only");
    wr_reg(ADDR_DATA, 16'h2201);
    rd_reg(ADDR_LATCH, d);
    `CHK(d[LAT_PEND], 1'b1, "accepted");
    flush();
  endtask
  task automatic t_thresh;
    logic [15:0] d;
    logic [15:0] p;
    int k;
    wr_reg(ADDR_CTRL, 16'h1F10);
    rd_reg(ADDR_STAT, p);
    k = 0;
    d = p;
    while (d[STAT_AVAIL] === 1'b1 && k < 16) begin
      p = d;
      wr_reg(ADDR_DATA, 16'h4400);
      k++;
      rd_reg(ADDR_STAT, d);
    end
    `CHK(p[STAT_AVAIL], 1'b1, "avail before");
    `CHK(d[13:8], 6'h1F, "level at drop");
    `CHK(k >= 8 && k <= 10, 1'b1, "writes to drop");
    wr_reg(ADDR_CTRL, 16'h1E10);
    rd_reg(ADDR_STAT, d);
    `CHK(d[STAT_AVAIL], 1'b1, "lower threshold");
    flush();
  endtask
  task automatic t_frames;
    logic [15:0] modes[6] = '{16'h0010, 16'h0018, 16'h0030, 16'h0012,
      16'h0014, 16'h0000};
    logic e[$];
    logic [15:0] d;
    run = 1'b1;
    foreach (modes[i]) begin
      slow = (i == 1);
      wr_reg(ADDR_CTRL, modes[i]);
      wr_reg(ADDR_LATCH, 16'h0008);
      sink.got.delete();
      send_pkt();
      repeat (260) @(posedge ref_clk);
      build(modes[i], e);
      `CHK(found(e), 1'b1, "frame");
      rd_reg(ADDR_LATCH, d);
      `CHK(d[LAT_PEND], 1'b1, "end latched");
    end
    slow = 1'b0;
  endtask
  task automatic t_inhibit;
    logic e[$];
    wr_reg(ADDR_CTRL, 16'h0050);
    // let the bit launched under the old fill reach the sink first
    @(posedge ref_clk);
    #1;
    sink.got.delete();
    send_pkt();
    repeat (150) @(posedge ref_clk);
    e = {1'b0};
    `CHK(found(e), 1'b0, "held off");
    wr_reg(ADDR_CTRL, 16'h0010);
    repeat (200) @(posedge ref_clk);
    build(16'h0010, e);
    `CHK(found(e), 1'b1, "released");
    wr_reg(ADDR_CTRL, 16'h0000);
    sink.got.delete();
    repeat (40) @(posedge ref_clk);
    e = {};
    for (int i = 0; i < 16; i++) e.push_back(FLAG_OCTET[i%8]);
    `CHK(found(e), 1'b1, "flag fill");
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    resetn = 1'b1;
    t_reset();
    t_fill_flush();
    t_thresh();
    t_frames();
    t_inhibit();
    complete_run();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    errors++;
    complete_run();
  end
endmodule
`default_nettype wire
